// ==== rtl/ead_decoder.sv ====
// Effective address decoder: operand selection and address forming
// Function
// - Accumulator is 32 bits; byte/word/long slices
// - Upper half 31:16, lower half 15:0
// - Stack pointer and bank follow selection
// - Byte, word, low word, long register selects
// - Short I/O form reaches 0000h to 00FFh
// - Immediate byte sign-extends to sixteen bits
// - Vector numbers in four or eight bits
// - Codes 00-07 are register direct, no extension
// - Codes 08-0F indirect, 0C-0F post-increment
// - Codes 10-17 add one-byte displacement
// - Codes 18-1B add two-byte displacement
// - Codes 1C/1D add word register 7
// - 1E program counter relative, 1F direct
// - Codes 00-07 register, 08-1F memory
// - Physical address: low sixteen, bank high byte
`timescale 1ns/1ps
module ead_decoder
  import ead_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Decode request
  input wire logic ea_valid_i,
  input wire logic [EAD_CODE_W-1:0] ea_code_i,
  input wire ead_width_t op_width_i,
  input wire logic [7:0] ext_byte0_i,
  input wire logic [7:0] ext_byte1_i,
  input wire logic [15:0] pc_i,
  // Decode result
  output logic ea_valid_o,
  output logic is_register_o,
  output logic is_memory_o,
  output logic [1:0] ext_bytes_o,
  output logic [15:0] mem_addr_o,
  output logic [31:0] reg_operand_o,
  // Word register write
  input wire logic reg_we_i,
  input wire logic [2:0] word_register_sel_i,
  input wire logic [15:0] reg_wdata_i,
  // Accumulator
  input wire logic acc_we_i,
  input wire ead_width_t acc_width_i,
  input wire logic [31:0] acc_wdata_i,
  output logic [15:0] acc_upper_half_o,
  output logic [15:0] acc_lower_half_o,
  output logic [31:0] acc_operand_o,
  // Stack
  input wire logic stack_user_sel_i,
  input wire logic sp_we_i,
  input wire logic [15:0] sp_wdata_i,
  input wire logic bank_we_i,
  input wire logic [7:0] bank_wdata_i,
  output logic [15:0] current_stack_pointer_o,
  output logic [7:0] current_stack_bank_o,
  // Operand conversions
  input wire logic [7:0] io_offset_i,
  input wire logic [7:0] imm8_i,
  input wire logic [3:0] short_vector_number_i,
  input wire logic [7:0] long_vector_number_i,
  input wire logic [23:0] physical_direct_address_i,
  output logic [23:0] io_addr_o,
  output logic [15:0] sign_extended_immediate_o,
  output logic [7:0] vector_number_o,
  input wire logic vector_long_i,
  output logic [15:0] phys_offset_o,
  output logic [7:0] phys_bank_o
);
  logic [EAD_NUM_WORDS*EAD_WORD_W-1:0] words;
  logic [15:0] rw [EAD_NUM_WORDS];
  logic [31:0] acc;
  logic [15:0] user_stack_pointer;
  logic [15:0] system_stack_pointer;
  logic [7:0] user_stack_bank;
  logic [7:0] system_stack_bank;
  logic inc_en;
  logic [15:0] inc_amt;
  logic [15:0] long_displacement;
  logic [15:0] next_addr;
  logic [1:0] next_ext;
  logic [31:0] next_reg_operand;

  for (genvar i = 0; i < EAD_NUM_WORDS; i++) begin : g_rw
    assign rw[i] = words[i*EAD_WORD_W +: EAD_WORD_W];
  end

  assign long_displacement = {ext_byte1_i, ext_byte0_i};
  assign inc_en = ea_valid_i && ea_code_i >= EAD_FIRST_PINC
    && ea_code_i < EAD_FIRST_D8;

  always_comb begin
    case (op_width_i)
      EAD_BYTE: inc_amt = EAD_STEP_BYTE;
      EAD_LONG: inc_amt = EAD_STEP_LONG;
      default: inc_amt = EAD_STEP_WORD;
    endcase
  end

  ead_word_regfile #(
    .NUM(EAD_NUM_WORDS),
    .W(EAD_WORD_W)
  ) u_regs (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .wr_en_i(reg_we_i),
    .wr_idx_i(word_register_sel_i),
    .wr_data_i(reg_wdata_i),
    .inc_en_i(inc_en),
    .inc_idx_i({1'b0, ea_code_i[1:0]}),
    .inc_amt_i(inc_amt),
    .words_o(words)
  );

  // Register operand: byte, word or long register from the code
  always_comb begin
    logic [2:0] n;
    n = ea_code_i[2:0];
    case (op_width_i)
      EAD_BYTE: next_reg_operand = {24'h000000, n[0] ?
        rw[{1'b0, n[2:1]}][15:8] : rw[{1'b0, n[2:1]}][7:0]};
      EAD_LONG: next_reg_operand = {rw[{n[2:1], 1'b1}],
        rw[{n[2:1], 1'b0}]};
      default: next_reg_operand = {16'h0000, rw[n]};
    endcase
  end

  // Address forming, all sums wrap at 16 bits
  always_comb begin
    next_addr = 16'h0000;
    next_ext = EAD_EXT_NONE;
    if (ea_code_i < EAD_FIRST_MEM) begin
      next_ext = EAD_EXT_NONE;
    end else if (ea_code_i < EAD_FIRST_D8) begin
      next_addr = rw[{1'b0, ea_code_i[1:0]}];
    end else if (ea_code_i < EAD_FIRST_D16) begin
      next_addr = rw[ea_code_i[2:0]] +
        {{8{ext_byte0_i[7]}}, ext_byte0_i};
      next_ext = EAD_EXT_ONE;
    end else if (ea_code_i < EAD_CODE_IX0) begin
      next_addr = rw[{1'b0, ea_code_i[1:0]}] + long_displacement;
      next_ext = EAD_EXT_TWO;
    end else if (ea_code_i == EAD_CODE_IX0) begin
      next_addr = rw[EAD_IDX_RW0] + rw[EAD_IDX_RW7];
    end else if (ea_code_i == EAD_CODE_IX1) begin
      next_addr = rw[EAD_IDX_RW1] + rw[EAD_IDX_RW7];
    end else if (ea_code_i == EAD_CODE_PCD) begin
      next_addr = pc_i + long_displacement;
      next_ext = EAD_EXT_TWO;
    end else if (ea_code_i == EAD_CODE_DIR) begin
      next_addr = long_displacement;
      next_ext = EAD_EXT_TWO;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ea_valid_o <= 1'b0;
      is_register_o <= 1'b0;
      is_memory_o <= 1'b0;
      ext_bytes_o <= EAD_EXT_NONE;
      mem_addr_o <= 16'h0000;
      reg_operand_o <= 32'h00000000;
    end else begin
      ea_valid_o <= ea_valid_i;
      is_register_o <= ea_valid_i && ea_code_i < EAD_FIRST_MEM;
      is_memory_o <= ea_valid_i && ea_code_i >= EAD_FIRST_MEM;
      ext_bytes_o <= next_ext;
      mem_addr_o <= next_addr;
      reg_operand_o <= next_reg_operand;
    end
  end

  // Accumulator with width-dependent write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc <= 32'h00000000;
    end else if (acc_we_i) begin
      case (acc_width_i)
        EAD_BYTE: acc[7:0] <= acc_wdata_i[7:0];
        EAD_WORD: acc[15:0] <= acc_wdata_i[15:0];
        default: acc <= acc_wdata_i;
      endcase
    end
  end

  assign acc_upper_half_o = acc[31:16];
  assign acc_lower_half_o = acc[15:0];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc_operand_o <= 32'h00000000;
    end else begin
      case (acc_width_i)
        EAD_BYTE: acc_operand_o <= {24'h000000, acc[7:0]};
        EAD_WORD: acc_operand_o <= {16'h0000, acc[15:0]};
        default: acc_operand_o <= acc;
      endcase
    end
  end

  // Stack pointers and banks; writes go to the selected pair
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      user_stack_pointer <= 16'h0000;
      system_stack_pointer <= 16'h0000;
      user_stack_bank <= 8'h00;
      system_stack_bank <= 8'h00;
    end else begin
      if (sp_we_i && stack_user_sel_i) user_stack_pointer <= sp_wdata_i;
      if (sp_we_i && !stack_user_sel_i) system_stack_pointer <= sp_wdata_i;
      if (bank_we_i && stack_user_sel_i) user_stack_bank <= bank_wdata_i;
      if (bank_we_i && !stack_user_sel_i) system_stack_bank <= bank_wdata_i;
    end
  end

  assign current_stack_pointer_o = stack_user_sel_i ?
    user_stack_pointer : system_stack_pointer;
  assign current_stack_bank_o = stack_user_sel_i ?
    user_stack_bank : system_stack_bank;

  // Operand conversions, registered
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      io_addr_o <= 24'h000000;
      sign_extended_immediate_o <= 16'h0000;
      vector_number_o <= 8'h00;
      phys_offset_o <= 16'h0000;
      phys_bank_o <= 8'h00;
    end else begin
      io_addr_o <= {EAD_IO_UPPER, io_offset_i};
      sign_extended_immediate_o <= {{8{imm8_i[7]}}, imm8_i};
      vector_number_o <= vector_long_i ? long_vector_number_i :
        {EAD_VCT_PAD, short_vector_number_i};
      phys_offset_o <= physical_direct_address_i[15:0];
      phys_bank_o <= physical_direct_address_i[23:16];
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_class;
    ea_valid_i |=> (is_register_o == ($past(ea_code_i) < EAD_FIRST_MEM))
      && (is_memory_o != is_register_o);
  endproperty
  a_class: assert property (p_class) else $error("class wrong");

  property p_ext;
    ea_valid_i && ea_code_i >= EAD_FIRST_D8 && ea_code_i < EAD_FIRST_D16 |=>
      ext_bytes_o == EAD_EXT_ONE;
  endproperty
  a_ext: assert property (p_ext) else $error("short displacement count");

  property p_d16;
    ea_valid_i && ea_code_i >= EAD_FIRST_D16 && ea_code_i < EAD_CODE_IX0 |=>
      ext_bytes_o == EAD_EXT_TWO
      && mem_addr_o == 16'($past(rw[{1'b0, ea_code_i[1:0]}])
      + $past(long_displacement));
  endproperty
  a_d16: assert property (p_d16) else $error("long displacement address");

  property p_ix;
    ea_valid_i && ea_code_i == EAD_CODE_IX1 |=> ext_bytes_o == EAD_EXT_NONE
      && mem_addr_o == 16'($past(rw[EAD_IDX_RW1]) + $past(rw[EAD_IDX_RW7]));
  endproperty
  a_ix: assert property (p_ix) else $error("index address");

  property p_pinc;
    inc_en && !reg_we_i && op_width_i == EAD_LONG |=>
      rw[{1'b0, $past(ea_code_i[1:0])}] ==
      16'($past(rw[{1'b0, ea_code_i[1:0]}]) + EAD_STEP_LONG);
  endproperty
  a_pinc: assert property (p_pinc) else $error("post increment");

  property p_io;
    ##1 io_addr_o[23:8] == EAD_IO_UPPER && io_addr_o[7:0] == $past(io_offset_i);
  endproperty
  a_io: assert property (p_io) else $error("io address");

  property p_sext;
    ##1 sign_extended_immediate_o[15:8] == {8{$past(imm8_i[7])}};
  endproperty
  a_sext: assert property (p_sext) else $error("sign extension");

  property p_acc;
    acc_we_i && acc_width_i == EAD_BYTE |=>
      acc_upper_half_o == $past(acc_upper_half_o)
      && acc_lower_half_o[15:8] == $past(acc_lower_half_o[15:8]);
  endproperty
  a_acc: assert property (p_acc) else $error("byte write spill");

  property p_phys;
    ##1 {phys_bank_o, phys_offset_o} == $past(physical_direct_address_i);
  endproperty
  a_phys: assert property (p_phys) else $error("physical split");

  property p_stack;
    sp_we_i && stack_user_sel_i ##1 stack_user_sel_i |->
      current_stack_pointer_o == $past(sp_wdata_i);
  endproperty
  a_stack: assert property (p_stack) else $error("stack select");

  c_reg: cover property (ea_valid_i && ea_code_i < EAD_FIRST_MEM);
  c_pinc: cover property (inc_en ##1 inc_en);
  c_pcd: cover property (ea_valid_i && ea_code_i == EAD_CODE_PCD);
  c_dir: cover property (ea_valid_i && ea_code_i == EAD_CODE_DIR);
endmodule : ead_decoder

// ==== rtl/ead_pkg.sv ====
// Constants and types shared by the effective address decoder
package ead_pkg;
  localparam int EAD_WORD_W = 16;
  localparam int EAD_ACC_W = 32;
  localparam int EAD_NUM_WORDS = 8;
  localparam int EAD_CODE_W = 5;
  localparam int EAD_BANK_W = 8;

  // Operand width, one-hot
  typedef enum logic [2:0] {
    EAD_BYTE = 3'b001,
    EAD_WORD = 3'b010,
    EAD_LONG = 3'b100
  } ead_width_t;

  // Address field code group bounds and fixed codes
  localparam logic [4:0] EAD_FIRST_PINC = 5'h0c;
  localparam logic [4:0] EAD_FIRST_D8 = 5'h10;
  localparam logic [4:0] EAD_FIRST_D16 = 5'h18;
  localparam logic [4:0] EAD_CODE_IX0 = 5'h1c;
  localparam logic [4:0] EAD_CODE_IX1 = 5'h1d;
  localparam logic [4:0] EAD_CODE_PCD = 5'h1e;
  localparam logic [4:0] EAD_CODE_DIR = 5'h1f;
  localparam logic [4:0] EAD_FIRST_MEM = 5'h08;

  // Register indices used by fixed modes
  localparam logic [2:0] EAD_IDX_RW0 = 3'h0;
  localparam logic [2:0] EAD_IDX_RW1 = 3'h1;
  localparam logic [2:0] EAD_IDX_RW7 = 3'h7;

  // Extension byte counts
  localparam logic [1:0] EAD_EXT_NONE = 2'h0;
  localparam logic [1:0] EAD_EXT_ONE = 2'h1;
  localparam logic [1:0] EAD_EXT_TWO = 2'h2;

  // Post-increment step in bytes
  localparam logic [15:0] EAD_STEP_BYTE = 16'h0001;
  localparam logic [15:0] EAD_STEP_WORD = 16'h0002;
  localparam logic [15:0] EAD_STEP_LONG = 16'h0004;

  // Short I/O region upper address bits and short vector number padding
  localparam logic [15:0] EAD_IO_UPPER = 16'h0000;
  localparam logic [3:0] EAD_VCT_PAD = 4'h0;
endpackage : ead_pkg

// ==== rtl/ead_word_regfile.sv ====
// Eight general word registers with a write port and a post-increment port
`timescale 1ns/1ps
module ead_word_regfile
  import ead_pkg::*;
#(
  parameter int NUM = EAD_NUM_WORDS,
  parameter int W = EAD_WORD_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Write port, wins over an increment of the same register
  input wire logic wr_en_i,
  input wire logic [$clog2(NUM)-1:0] wr_idx_i,
  input wire logic [W-1:0] wr_data_i,
  // Post-increment port
  input wire logic inc_en_i,
  input wire logic [$clog2(NUM)-1:0] inc_idx_i,
  input wire logic [W-1:0] inc_amt_i,
  // All registers, word i at bits i*W
  output logic [NUM*W-1:0] words_o
);
  for (genvar i = 0; i < NUM; i++) begin : g_word
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        words_o[i*W +: W] <= '0;
      end else if (wr_en_i && wr_idx_i == i) begin
        words_o[i*W +: W] <= wr_data_i;
      end else if (inc_en_i && inc_idx_i == i) begin
        words_o[i*W +: W] <= words_o[i*W +: W] + inc_amt_i;
      end
    end
  end
endmodule : ead_word_regfile

// ==== tb/ead_queue_model.sv ====
// Instruction queue model: extension bytes and program counter
`timescale 1ns/1ps
module ead_queue_model (
  // Clock
  input wire logic sys_clk_i,
  // Extension bytes and program counter toward the decoder
  output logic [7:0] ext_byte0_o,
  output logic [7:0] ext_byte1_o,
  output logic [15:0] pc_o
);
  initial begin
    ext_byte0_o = 8'h00;
    ext_byte1_o = 8'h00;
    pc_o = 16'h0000;
  end

  // Fresh bytes every cycle, so an unused byte never holds a stale value
  always @(posedge sys_clk_i) begin
    ext_byte0_o <= 8'($urandom);
    ext_byte1_o <= 8'($urandom);
    pc_o <= 16'($urandom);
  end
endmodule : ead_queue_model

// ==== tb/tb_effective_address_decoder.sv ====
// Self-checking testbench for the effective address decoder
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_effective_address_decoder;
  import ead_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ea_valid_i = 1'b0;
  logic [4:0] ea_code_i = 5'h00;
  ead_width_t op_width_i = EAD_WORD;
  ead_width_t acc_width_i = EAD_LONG;
  logic [7:0] ext_byte0_i, ext_byte1_i;
  logic [15:0] pc_i;
  logic reg_we_i = 1'b0, acc_we_i = 1'b0, stack_user_sel_i = 1'b0;
  logic sp_we_i = 1'b0, bank_we_i = 1'b0, vector_long_i = 1'b0;
  logic [2:0] word_register_sel_i = 3'h0;
  logic [15:0] reg_wdata_i = 16'h0000, sp_wdata_i = 16'h0000;
  logic [31:0] acc_wdata_i = 32'h0000_0000;
  logic [7:0] bank_wdata_i = 8'h00, io_offset_i = 8'h00, imm8_i = 8'h00;
  logic [3:0] short_vector_number_i = 4'h0;
  logic [7:0] long_vector_number_i = 8'h00;
  logic [23:0] physical_direct_address_i = 24'h000000;
  logic ea_valid_o, is_register_o, is_memory_o;
  logic [1:0] ext_bytes_o;
  logic [15:0] mem_addr_o, acc_upper_half_o, acc_lower_half_o;
  logic [15:0] current_stack_pointer_o, sign_extended_immediate_o;
  logic [15:0] phys_offset_o;
  logic [31:0] reg_operand_o, acc_operand_o;
  logic [7:0] current_stack_bank_o, vector_number_o, phys_bank_o;
  logic [23:0] io_addr_o;
  logic [15:0] rw [8];
  logic [123:0] q [$];
  logic [123:0] n;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  ead_width_t widths [3] = '{EAD_BYTE, EAD_WORD, EAD_LONG};
  logic [31:0] acc_ops [3] = '{32'h0000_0078, 32'h0000_5678, 32'h89ab_5678};

  ead_decoder dut (
    .sys_clk_i, .srst_i, .ea_valid_i, .ea_code_i, .op_width_i, .ext_byte0_i,
    .ext_byte1_i, .pc_i, .ea_valid_o, .is_register_o, .is_memory_o,
    .ext_bytes_o, .mem_addr_o, .reg_operand_o, .reg_we_i,
    .word_register_sel_i, .reg_wdata_i, .acc_we_i, .acc_width_i,
    .acc_wdata_i, .acc_upper_half_o, .acc_lower_half_o, .acc_operand_o,
    .stack_user_sel_i, .sp_we_i, .sp_wdata_i, .bank_we_i, .bank_wdata_i,
    .current_stack_pointer_o, .current_stack_bank_o, .io_offset_i, .imm8_i,
    .short_vector_number_i, .long_vector_number_i,
    .physical_direct_address_i, .io_addr_o, .sign_extended_immediate_o,
    .vector_number_o, .vector_long_i, .phys_offset_o, .phys_bank_o
  );

  ead_queue_model queue (.sys_clk_i, .ext_byte0_o(ext_byte0_i),
    .ext_byte1_o(ext_byte1_i), .pc_o(pc_i));

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Decode result as {register, memory, extension count, address, operand}
  function automatic logic [51:0] dec_exp(input logic [4:0] c,
      input ead_width_t w, input logic [15:0] d, input logic [15:0] pc);
    logic [15:0] a;
    logic [31:0] r;
    logic [1:0] e;
    a = 16'h0000;
    r = 32'h0000_0000;
    e = 2'h0;
    if (c < 5'h08) begin
      if (w == EAD_BYTE) begin
        r = {24'h0, c[0] ? rw[c[2:1]][15:8] : rw[c[2:1]][7:0]};
      end else if (w == EAD_WORD) begin
        r = {16'h0, rw[c[2:0]]};
      end else begin
        r = {rw[{c[2:1], 1'b1}], rw[{c[2:1], 1'b0}]};
      end
    end else if (c < 5'h10) begin
      a = rw[c[1:0]];
    end else if (c < 5'h18) begin
      a = rw[c[2:0]] + {{8{d[7]}}, d[7:0]};
      e = 2'h1;
    end else if (c < 5'h1c) begin
      a = rw[c[1:0]] + d;
      e = 2'h2;
    end else if (c < 5'h1e) begin
      a = rw[{2'b00, c[0]}] + rw[7];
    end else begin
      a = (c == 5'h1e) ? pc + d : d;
      e = 2'h2;
    end
    return {c < 5'h08, c >= 5'h08, e, a, r};
  endfunction : dec_exp

  task automatic drive_one;
    logic [4:0] c;
    ead_width_t w;
    @(negedge sys_clk_i);
    c = 5'($urandom);
    w = widths[$urandom % 3];
    ea_valid_i = ($urandom % 4) != 0;
    ea_code_i = c;
    op_width_i = w;
    reg_we_i = ($urandom % 3) == 0;
    word_register_sel_i = 3'($urandom);
    reg_wdata_i = 16'($urandom);
    io_offset_i = 8'($urandom);
    imm8_i = 8'($urandom);
    short_vector_number_i = 4'($urandom);
    long_vector_number_i = 8'($urandom);
    vector_long_i = 1'($urandom);
    physical_direct_address_i = 24'($urandom);
    if (ea_valid_i) begin
      q.push_back({dec_exp(c, w, {ext_byte1_i, ext_byte0_i}, pc_i),
        16'h0000, io_offset_i, {{8{imm8_i[7]}}, imm8_i},
        vector_long_i ? long_vector_number_i : {4'h0, short_vector_number_i},
        physical_direct_address_i[15:0], physical_direct_address_i[23:16]});
      if (c[4:2] == 3'b011) begin
        rw[c[1:0]] += (w == EAD_BYTE) ? 16'h1 : (w == EAD_WORD) ? 16'h2 : 16'h4;
      end
    end
    // A register write wins over an increment of the same register
    if (reg_we_i) begin
      rw[word_register_sel_i] = reg_wdata_i;
    end
  endtask : drive_one

  task automatic acc_wr(input ead_width_t w, input logic [31:0] d,
      input logic [31:0] exp);
    @(negedge sys_clk_i);
    acc_we_i = 1'b1;
    acc_width_i = w;
    acc_wdata_i = d;
    @(negedge sys_clk_i);
    acc_we_i = 1'b0;
    `CHK({acc_upper_half_o, acc_lower_half_o}, exp)
  endtask : acc_wr

  always @(negedge sys_clk_i) begin
    if (ea_valid_o === 1'b1) begin
      n = q.pop_front();
      `CHK({is_register_o, is_memory_o, ext_bytes_o, mem_addr_o, n[122] ? 32'h0 : reg_operand_o}, n[123:72])
      `CHK({io_addr_o, sign_extended_immediate_o, vector_number_o, phys_offset_o, phys_bank_o}, n[71:0])
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    void'($urandom(1));
    foreach (rw[i]) rw[i] = 16'h0000;
    repeat (10) @(negedge sys_clk_i);
    srst_i = 1'b0;
    repeat (400) drive_one();
    @(negedge sys_clk_i);
    ea_valid_i = 1'b0;
    reg_we_i = 1'b0;
    acc_wr(EAD_LONG, 32'h89ab_cdef, 32'h89ab_cdef);
    acc_wr(EAD_BYTE, 32'h5555_5512, 32'h89ab_cd12);
    acc_wr(EAD_WORD, 32'h5555_5678, 32'h89ab_5678);
    for (int i = 0; i < 3; i++) begin
      acc_width_i = widths[i];
      repeat (2) @(negedge sys_clk_i);
      `CHK(acc_operand_o, acc_ops[i])
    end
    for (int s = 0; s < 2; s++) begin
      @(negedge sys_clk_i);
      stack_user_sel_i = 1'(s);
      sp_we_i = 1'b1;
      bank_we_i = 1'b1;
      sp_wdata_i = 16'ha5a0 + 16'(s);
      bank_wdata_i = 8'h30 + 8'(s);
    end
    @(negedge sys_clk_i);
    sp_we_i = 1'b0;
    bank_we_i = 1'b0;
    for (int s = 1; s >= 0; s--) begin
      stack_user_sel_i = 1'(s);
      @(negedge sys_clk_i);
      `CHK({current_stack_pointer_o, current_stack_bank_o}, {16'ha5a0 + 16'(s), 8'h30 + 8'(s)})
    end
    // Every noted decode must have come back
    `CHK(q.size(), 0)
    repeat (2) @(negedge sys_clk_i);
    end_sim();
  end
endmodule : tb_effective_address_decoder
